// >>> dsr_top.sv
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "dsr_params.svh"
// Overview of operation
// - Idle bit set by debug mode or breakpoint
// - Idle reads 0 running, 1 stopped/spinning
// - Bit 6 mirrors halt mode
// - Bit 5 is inverted read-protect option
// - Halt request stops fetch, auto-sets on breakpoint unless spin is selected
// - Breakpoint enters debug, spins, or is no-op
module dsr_top
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic brk_decoded,
  input wire logic halt_mode,
  input wire logic read_protect_option,
  input wire logic cpu_reset_done,
  output logic cpu_fetch_stall,
  output logic cpu_spin_on_brk,
  output logic brk_as_nop,
  output logic cpu_reset_req,
  output logic debug_ack_enable
);

  // ----------------------------------------
  // Address decode helper
  // ----------------------------------------
  // Word match on the byte address, low two bits ignored
  function automatic logic dsr_hit(input logic [3:0] adr, input logic [3:0] ofs);
    dsr_hit = (adr[3:2] == ofs[3:2]);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dsr_brk_if brk ();

  dsr_bus_state_t bus_state_ff;
  dsr_bus_state_t nxt_bus_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  dsr_byte_t control_ff;
  dsr_byte_t nxt_control;
  dsr_byte_t status_ff;
  dsr_byte_t nxt_status;
  logic halt_req_ff;
  logic nxt_halt_req;
  logic reset_req_ff;
  logic stall_ff;
  logic spin_out_ff;
  logic nop_out_ff;
  logic ctl_wr_ff;
  logic req;
  logic take;
  logic ctl_wr;
  logic prot_active;
  dsr_byte_t wdata;

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  // A request is taken once, in the idle state only
  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & (bus_state_ff == DSR_BUS_IDLE);
  // Control write needs byte lane 0, where the byte lives
  assign ctl_wr = take & wb_we_i & wb_sel_i[0] & dsr_hit(wb_adr_i, `DSR_OFS_CONTROL);
  assign wdata = wb_dat_i[7:0];
  // Protection is in force when the option bit is programmed to 0
  assign prot_active = ~read_protect_option;

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  // Ack one cycle after the request, then drop it for a cycle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      DSR_BUS_IDLE: begin
        if (req) begin
          nxt_bus_state = DSR_BUS_ACK;
        end
      end
      DSR_BUS_ACK: begin
        nxt_bus_state = DSR_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = DSR_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_state_ff <= DSR_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Ack registered so that it leaves straight from a flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped words still ack, reading zero, so a host never hangs
  always_comb begin
    nxt_rdata = rdata_ff;
    if (take) begin
      nxt_rdata = 32'h0000_0000;
      if (!wb_we_i && dsr_hit(wb_adr_i, `DSR_OFS_STATUS)) begin
        nxt_rdata = {24'h00_0000, status_ff};
      end else if (!wb_we_i && dsr_hit(wb_adr_i, `DSR_OFS_CONTROL)) begin
        nxt_rdata = {24'h00_0000, control_ff};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Spin, allow and ack-enable bits follow the write directly;
  // reserved bits 3:1 are masked off so they stay zero
  always_comb begin
    nxt_control = control_ff;
    if (ctl_wr) begin
      nxt_control = wdata & `DSR_CONTROL_WMASK;
    end
    nxt_control[`DSR_CT_HALT_REQ] = nxt_halt_req;
    nxt_control[`DSR_CT_RESET] = reset_req_ff;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_ff <= `DSR_CONTROL_RESET;
    end else begin
      control_ff <= nxt_control;
    end
  end

  // Halt request: breakpoint entry wins over a clearing write;
  // under read protection it can only be left through reset
  always_comb begin
    nxt_halt_req = halt_req_ff;
    if (ctl_wr) begin
      nxt_halt_req = wdata[`DSR_CT_HALT_REQ] | (halt_req_ff & prot_active);
    end
    if (brk.enter_debug) begin
      nxt_halt_req = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      halt_req_ff <= 1'b0;
    end else begin
      halt_req_ff <= nxt_halt_req;
    end
  end

  // Device reset request, cleared by the core when reset finishes;
  // a new write in the finishing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reset_req_ff <= 1'b0;
    end else if (ctl_wr && wdata[`DSR_CT_RESET]) begin
      reset_req_ff <= 1'b1;
    end else if (cpu_reset_done) begin
      reset_req_ff <= 1'b0;
    end
  end

  // One-cycle marker that control was just written
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl_wr_ff <= 1'b0;
    end else begin
      ctl_wr_ff <= ctl_wr;
    end
  end

  // ----------------------------------------
  // Breakpoint tracker
  // ----------------------------------------
  // Fed from registered control so decode timing is fixed
  assign brk.brk_decoded = brk_decoded;
  assign brk.brk_allow = control_ff[`DSR_CT_BRK_ALLOW];
  assign brk.spin_sel = control_ff[`DSR_CT_SPIN_SEL];
  assign brk.ctl_write = ctl_wr_ff;

  dsr_brk_tracker u_brk (
    .clk(clk),
    .reset_n(reset_n),
    .brk(brk.tracker)
  );

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  // Built only from live state; no bus write path reaches it
  always_comb begin
    nxt_status = 8'h00;
    nxt_status[`DSR_ST_IDLE] = halt_req_ff | brk.brk_seen;
    nxt_status[`DSR_ST_HALT] = halt_mode;
    nxt_status[`DSR_ST_RDPROT] = prot_active;
  end

  // Written every cycle from state, never from wb_dat_i
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_ff <= `DSR_STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ----------------------------------------
  // Core-facing outputs
  // ----------------------------------------
  // Registered copies cost a cycle of latency but keep outputs clean
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= halt_req_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spin_out_ff <= 1'b0;
    end else begin
      spin_out_ff <= brk.spin_active;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nop_out_ff <= 1'b0;
    end else begin
      nop_out_ff <= brk.brk_nop;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign cpu_fetch_stall = stall_ff;
  assign cpu_spin_on_brk = spin_out_ff;
  assign brk_as_nop = nop_out_ff;
  assign cpu_reset_req = reset_req_ff;
  assign debug_ack_enable = control_ff[`DSR_CT_ACK_EN];

endmodule

// >>> dsr_params.svh
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSR_OFS_STATUS 4'h0
`define DSR_OFS_CONTROL 4'h4

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define DSR_ST_IDLE 7
`define DSR_ST_HALT 6
`define DSR_ST_RDPROT 5

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define DSR_CT_HALT_REQ 7
`define DSR_CT_BRK_ALLOW 6
`define DSR_CT_ACK_EN 5
`define DSR_CT_SPIN_SEL 4
`define DSR_CT_RESET 0

// ----------------------------------------
// Reset values and control write mask
// ----------------------------------------
`define DSR_CONTROL_RESET 8'h00
`define DSR_STATUS_RESET 8'h00
`define DSR_CONTROL_WMASK 8'hf1

`endif

// >>> dsr_pkg.sv
package dsr_pkg;
  // Bus slave states
  typedef enum logic [0:0] {
    DSR_BUS_IDLE = 1'b0,
    DSR_BUS_ACK = 1'b1
  } dsr_bus_state_t;

  typedef logic [7:0] dsr_byte_t;
endpackage

// >>> dsr_brk_if.sv
`timescale 1ns/1ps
// Breakpoint decode path between control logic and tracker
interface dsr_brk_if;
  logic brk_decoded;
  logic brk_allow;
  logic spin_sel;
  logic ctl_write;
  logic enter_debug;
  logic spin_active;
  logic brk_seen;
  logic brk_nop;

  modport tracker (
    input brk_decoded,
    input brk_allow,
    input spin_sel,
    input ctl_write,
    output enter_debug,
    output spin_active,
    output brk_seen,
    output brk_nop
  );

  modport ctrl (
    output brk_decoded,
    output brk_allow,
    output spin_sel,
    output ctl_write,
    input enter_debug,
    input spin_active,
    input brk_seen,
    input brk_nop
  );
endinterface

// >>> dsr_brk_tracker.sv
`timescale 1ns/1ps
module dsr_brk_tracker (
  input wire logic clk,
  input wire logic reset_n,
  dsr_brk_if.tracker brk
);
  logic hit;
  logic enter_ff;
  logic spin_ff;
  logic seen_ff;
  logic nop_ff;

  // A decode only counts as a breakpoint when allowed
  assign hit = brk.brk_decoded & brk.brk_allow;

  // ----------------------------------------
  // Breakpoint action
  // ----------------------------------------
  // One-cycle request to enter debug mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enter_ff <= 1'b0;
    end else begin
      enter_ff <= hit & ~brk.spin_sel;
    end
  end

  // Spin on the instruction until software rewrites control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spin_ff <= 1'b0;
    end else if (hit & brk.spin_sel) begin
      spin_ff <= 1'b1;
    end else if (brk.ctl_write) begin
      spin_ff <= 1'b0;
    end
  end

  // Sticky seen flag; a hit in the write cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seen_ff <= 1'b0;
    end else if (hit) begin
      seen_ff <= 1'b1;
    end else if (brk.ctl_write) begin
      seen_ff <= 1'b0;
    end
  end

  // Disabled breakpoints fall through as a no-operation
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nop_ff <= 1'b0;
    end else begin
      nop_ff <= brk.brk_decoded & ~brk.brk_allow;
    end
  end

  assign brk.enter_debug = enter_ff;
  assign brk.spin_active = spin_ff;
  assign brk.brk_seen = seen_ff;
  assign brk.brk_nop = nop_ff;
endmodule

// >>> dsr_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core side: decode, halt and option levels
// ----------------------------------------
module dsr_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic brk_cmd,
  input wire logic halt_lvl,
  input wire logic prot_lvl,
  input wire logic slow,
  input wire logic cpu_fetch_stall,
  input wire logic cpu_reset_req,
  output logic brk_decoded,
  output logic halt_mode,
  output logic read_protect_option,
  output logic cpu_reset_done
);
  logic [3:0] cnt_ff;
  // A stalled core fetches nothing, so it decodes no breakpoint
  always_ff @(posedge clk) begin
    brk_decoded <= reset_n && brk_cmd && !cpu_fetch_stall;
  end
  // Reset settles after a short or a long wait
  always_ff @(posedge clk) begin
    if (!reset_n || !cpu_reset_req) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'hf) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  assign cpu_reset_done = cpu_reset_req && (cnt_ff == (slow ? 4'hc : 4'h1));
  assign halt_mode = halt_lvl;
  assign read_protect_option = prot_lvl;
endmodule

// >>> dsr_top_asserts.sv
`timescale 1ns/1ps
module dsr_top_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic brk_decoded,
  input wire logic halt_mode,
  input wire logic read_protect_option,
  input wire logic cpu_reset_done,
  input wire logic cpu_fetch_stall,
  input wire logic cpu_spin_on_brk,
  input wire logic brk_as_nop,
  input wire logic cpu_reset_req,
  input wire logic debug_ack_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Bus steps and status read
  // ----------------------------------------
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Older samples must postdate reset, or stale levels would show
  sequence s_rd;
    wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0 && $past(reset_n, 4);
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_idle_set: assert property (
    s_rd ##0 ((cpu_fetch_stall && $past(cpu_fetch_stall)) || (cpu_spin_on_brk &&
    $past(cpu_spin_on_brk))) |-> wb_dat_o[7]) else $error("idle not set");
  a_idle_clear: assert property (
    s_rd ##0 (!cpu_fetch_stall && !$past(cpu_fetch_stall) && !$past(cpu_fetch_stall, 2)
    && !cpu_spin_on_brk && !$past(cpu_spin_on_brk)) |-> !wb_dat_o[7]) else $error("idle set");
  a_halt_bit: assert property (
    s_rd ##0 ($past(halt_mode) == $past(halt_mode, 2) && $past(halt_mode, 2) ==
    $past(halt_mode, 3)) |-> wb_dat_o[6] == $past(halt_mode, 2)) else $error("halt bit");
  a_protect_bit: assert property (
    s_rd ##0 ($past(read_protect_option) == $past(read_protect_option, 2) &&
    $past(read_protect_option, 2) == $past(read_protect_option, 3))
    |-> wb_dat_o[5] == !$past(read_protect_option, 2)) else $error("protect bit");
  a_nop_cause: assert property (brk_as_nop |-> $past(brk_decoded, 2)) else $error("nop");
  a_spin_cause: assert property (
    $rose(cpu_spin_on_brk) |-> $past(brk_decoded, 2)) else $error("spin");
  a_stall_cause: assert property (
    $rose(cpu_fetch_stall) |-> $past(brk_decoded, 3) ||
    $past(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o, 2)) else $error("stall");
endmodule
bind dsr_top dsr_top_asserts dsr_top_asserts_inst (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .brk_decoded(brk_decoded), .halt_mode(halt_mode), .read_protect_option(read_protect_option),
  .cpu_reset_done(cpu_reset_done), .cpu_fetch_stall(cpu_fetch_stall),
  .cpu_spin_on_brk(cpu_spin_on_brk), .brk_as_nop(brk_as_nop), .cpu_reset_req(cpu_reset_req),
  .debug_ack_enable(debug_ack_enable));

// >>> dsr_top_tb_top.sv
`timescale 1ns/1ps
module dsr_top_tb_top;
  logic clk, reset_n, cyc, stb, we, ack, brk_cmd, halt_lvl, prot_lvl, slow;
  logic brk_decoded, halt_mode, rpo, done, stall, spin, nop, rst_req, ack_en;
  logic [3:0] adr, sel;
  logic [31:0] dat, q;
  int n_mismatch, tests_run, tick, nops, nb;
  logic [7:0] ctl [3] = '{8'h00, 8'h40, 8'h50};
  logic [2:0] exp_out [3] = '{3'h1, 3'h4, 3'h2};
  dsr_top dsr_top_inst (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .brk_decoded(brk_decoded), .halt_mode(halt_mode),
    .read_protect_option(rpo), .cpu_reset_done(done), .cpu_fetch_stall(stall),
    .cpu_spin_on_brk(spin), .brk_as_nop(nop), .cpu_reset_req(rst_req),
    .debug_ack_enable(ack_en));
  dsr_core_model dsr_core_model_inst (.clk(clk), .reset_n(reset_n), .brk_cmd(brk_cmd),
    .halt_lvl(halt_lvl), .prot_lvl(prot_lvl), .slow(slow), .cpu_fetch_stall(stall),
    .cpu_reset_req(rst_req), .brk_decoded(brk_decoded), .halt_mode(halt_mode),
    .read_protect_option(rpo), .cpu_reset_done(done));
  // ----------------------------------------
  // Bus cycles, compares and verdict
  // ----------------------------------------
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Request holds until ack is seen high at a rising edge; no fixed latency assumed
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'h1, d};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Waits on rising edges so later drives stay on the rising edge
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Sticky count, since the no-op flag stands one cycle only
  always @(posedge clk) begin
    tick++;
    if (nop === 1'b1) nops++;
    if (tick == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {reset_n, cyc, stb, we, adr, sel, dat, brk_cmd, halt_lvl, slow} = '0;
    prot_lvl = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    halt_lvl <= 1'b1;
    rd(4'h0, 32'h40);
    prot_lvl <= 1'b0;
    rd(4'h0, 32'h60);
    {halt_lvl, prot_lvl} <= 2'h1;
    rd(4'h0, 32'h0);
    xfer(1'b1, 4'h0, 32'he0);
    rd(4'h0, 32'h0);
    xfer(1'b1, 4'h4, 32'h20);
    chk(ack_en, 1'b1);
    xfer(1'b1, 4'h4, 32'h80);
    chk(ack_en, 1'b0);
    idle(3);
    chk(stall, 1'b1);
    rd(4'h0, 32'h80);
    xfer(1'b1, 4'h4, 32'h0);
    idle(3);
    chk(stall, 1'b0);
    rd(4'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 4'h4, ctl[i]);
      nb = nops;
      @(posedge clk) brk_cmd <= 1'b1;
      @(posedge clk) brk_cmd <= 1'b0;
      idle(5);
      chk({stall, spin, nops != nb}, exp_out[i]);
      rd(4'h0, {24'h0, ctl[i][6], 7'h0});
      xfer(1'b1, 4'h4, 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      xfer(1'b1, 4'h4, 32'h1);
      chk(rst_req, 1'b1);
      idle(16);
      chk(rst_req, 1'b0);
    end
    prot_lvl <= 1'b0;
    xfer(1'b1, 4'h4, 32'h80);
    xfer(1'b1, 4'h4, 32'h0);
    idle(3);
    rd(4'h0, 32'ha0);
    prot_lvl <= 1'b1;
    conclude();
  end
endmodule
